// ==== include/tctm_pkg.sv ====
package tctm_pkg;

    typedef enum logic [6:0] {
        TCTM_IDLE     = 7'b0000001,
        TCTM_FETCH_WC = 7'b0000010,
        TCTM_FETCH_CA = 7'b0000100,
        TCTM_WAIT     = 7'b0001000,
        TCTM_XFER     = 7'b0010000,
        TCTM_WB_WC    = 7'b0100000,
        TCTM_WB_CA    = 7'b1000000
    } tctm_state_t;

    typedef enum logic {
        TCTM_FORMAT_PACED = 1'b0,
        TCTM_COUNT_PACED  = 1'b1
    } tctm_mode_t;

endpackage : tctm_pkg

// ==== include/tctm_regs.svh ====
`ifndef TCTM_REGS_SVH
`define TCTM_REGS_SVH

// register byte offsets
`define TCTM_OFS_CTRL     4'h0
`define TCTM_OFS_STATUS   4'h4
`define TCTM_OFS_MASK     4'h8
`define TCTM_OFS_INFO     4'hc

// control fields
`define TCTM_CTRL_MODE    0
`define TCTM_CTRL_START   1
`define TCTM_CTRL_CLRDONE 2

// status register b fields
`define TCTM_ST_TIMING    5
`define TCTM_ST_DONE      11

// info register fields
`define TCTM_INFO_WCFLAG  0
`define TCTM_INFO_MODE    1
`define TCTM_INFO_ACTIVE  2
`define TCTM_INFO_TMARK   3

// fixed core memory locations
`define TCTM_WC_LOC       15'h0018
`define TCTM_CA_LOC       15'h0019

`define TCTM_MASK_RST     32'h0000_0000

`endif

// ==== src/tctm_core.sv ====
`timescale 1ns/1ps
`include "tctm_regs.svh"
// Notes on behaviour
// R1: two modes, format-paced and count-paced, chosen by software, never by a switch.
// R2: format-paced mode: transfers and flags paced only by tape block structure.
// R3: count-paced mode also governed by word count fetched from location 000030.
// R4: each transfer address comes from current address word at location 000031.
// R5: count-paced mode suppresses completion flags until word count overflows.
// R6: data break requests only while no overflow during current function.
// R7: timing mark indicator lit while selector is in mark-writing position.
// R8: completion flag, status bit 11, set when each tape operation finishes.
// R9: word-count flag cleared whenever the word count overflows.
// R10: completion flag set again while still set records timing error, bit 5.
// R11: word count and current address advance by one per word; zero crossing overflows. The code advances the word count only in count-paced mode.
module tctm_core
    import tctm_pkg::*;
#(
    parameter int AW = 15,
    parameter int DW = 18
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // avalon-mm slave
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // interrupt
    output logic               irq,
    // data break channel to core memory
    output logic               brk_req,
    output logic               brk_we,
    output logic [AW-1:0]      brk_addr,
    output logic [DW-1:0]      brk_wdata,
    input  wire logic [DW-1:0] brk_rdata,
    input  wire logic          brk_ack,
    // tape side, same clock
    input  wire logic          tape_word_valid,
    input  wire logic [DW-1:0] tape_word,
    input  wire logic          tape_block_end,
    // panel
    input  wire logic          timing_mark_write_position,
    output logic               timing_mark_indicator
);

    initial begin
        if (AW < 15 || DW < 15 || DW > 32)
            $error("tctm_core: unsupported widths");
    end

    tctm_state_t       state;
    tctm_mode_t        mode;
    logic [DW-1:0]     word_count;
    logic [DW-1:0]     current_address;
    logic [DW-1:0]     data_hold;
    logic              word_count_flag;
    logic              overflowed;
    logic              completion_flag;
    logic              timing_err;
    logic [31:0]       mask;
    logic              pin_s1;
    logic              pin_s2;

    logic              wr_ctrl;
    logic              wr_status;
    logic              start_req;
    logic              finish_evt;
    tctm_mode_t        start_mode;
    logic              next_overflow;
    logic [DW-1:0]     next_wc;

    // one access per two cycles; single wait cycle keeps read data registered
    // writes land in the answer cycle, the only edge the master vouches for
    logic              acc_done;
    assign wr_ctrl   = avs_write && acc_done && avs_address == `TCTM_OFS_CTRL;
    assign wr_status = avs_write && acc_done && avs_address == `TCTM_OFS_STATUS;
    assign start_req = wr_ctrl && avs_writedata[`TCTM_CTRL_START] && state == TCTM_IDLE;
    // the mode written with start governs this function, not the old one
    assign start_mode = tctm_mode_t'(avs_writedata[`TCTM_CTRL_MODE]);       // R1
    assign next_wc   = word_count + {{(DW-1){1'b0}}, 1'b1};
    assign next_overflow = (next_wc == '0);                                    // R11

    // block end finishes format-paced, and count-paced only once overflowed; overflow finishes count-paced
    assign finish_evt = (state == TCTM_WAIT && tape_block_end && (mode == TCTM_FORMAT_PACED || overflowed)) // R2 R5
                     || (state == TCTM_WB_CA && brk_ack && overflowed && mode == TCTM_COUNT_PACED);       // R5

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_done        <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            acc_done        <= (avs_read || avs_write) && !acc_done;
            avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
            unique case (avs_address)
                `TCTM_OFS_CTRL:   avs_readdata <= {31'h0, mode};
                `TCTM_OFS_STATUS: avs_readdata <= {20'h0, completion_flag, 5'h0, timing_err, 5'h0};
                `TCTM_OFS_MASK:   avs_readdata <= mask;
                `TCTM_OFS_INFO:   avs_readdata <= {28'h0, timing_mark_indicator, state != TCTM_IDLE,
                                                   mode, word_count_flag};
                default:          avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // mode is software-owned only
    always_ff @(posedge clk_sys) begin
        if (rst)
            mode <= TCTM_FORMAT_PACED;
        else if (wr_ctrl && state == TCTM_IDLE)
            mode <= tctm_mode_t'(avs_writedata[`TCTM_CTRL_MODE]);                // R1
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            mask <= `TCTM_MASK_RST;
        else if (avs_write && acc_done && avs_address == `TCTM_OFS_MASK)
            mask <= avs_writedata;
    end

    // completion and timing flags; set beats write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            completion_flag <= 1'b0;
            timing_err      <= 1'b0;
        end else begin
            if (finish_evt)
                completion_flag <= 1'b1;                                          // R8
            else if ((wr_status && avs_writedata[`TCTM_ST_DONE])
                     || (wr_ctrl && avs_writedata[`TCTM_CTRL_CLRDONE]))
                completion_flag <= 1'b0;
            if (finish_evt && completion_flag)
                timing_err <= 1'b1;                                               // R10
            else if (wr_status && avs_writedata[`TCTM_ST_TIMING])
                timing_err <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= (completion_flag && mask[`TCTM_ST_DONE]) || (timing_err && mask[`TCTM_ST_TIMING]);
    end

    // switch is asynchronous to the clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s1                <= 1'b0;
            pin_s2                <= 1'b0;
            timing_mark_indicator <= 1'b0;
        end else begin
            pin_s1                <= timing_mark_write_position;
            pin_s2                <= pin_s1;
            timing_mark_indicator <= pin_s2;                                      // R7
        end
    end

    // transfer sequencer: fetch counters, move words, write counters back
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state           <= TCTM_IDLE;
            word_count      <= '0;
            current_address <= '0;
            data_hold       <= '0;
            word_count_flag <= 1'b0;
            overflowed      <= 1'b0;
        end else begin
            unique case (state)
                TCTM_IDLE: if (start_req) begin
                    overflowed      <= 1'b0;                                      // R6
                    word_count_flag <= 1'b1;
                    state           <= (start_mode == TCTM_COUNT_PACED) ? TCTM_FETCH_WC : TCTM_FETCH_CA; // R3
                end
                TCTM_FETCH_WC: if (brk_ack) begin
                    word_count <= brk_rdata;                                      // R3
                    state      <= TCTM_FETCH_CA;
                end
                TCTM_FETCH_CA: if (brk_ack) begin
                    current_address <= brk_rdata;                                 // R4
                    state           <= TCTM_WAIT;
                end
                TCTM_WAIT: begin
                    if (finish_evt)
                        state <= TCTM_IDLE;
                    else if (tape_word_valid && !overflowed) begin                // R6
                        data_hold <= tape_word;
                        state     <= TCTM_XFER;
                    end
                end
                TCTM_XFER: if (brk_ack) begin
                    current_address <= current_address + {{(DW-1){1'b0}}, 1'b1};  // R11
                    if (mode == TCTM_COUNT_PACED) begin
                        word_count <= next_wc;                                    // R11
                        if (next_overflow) begin
                            overflowed      <= 1'b1;
                            word_count_flag <= 1'b0;                              // R9
                        end
                    end
                    state <= (mode == TCTM_COUNT_PACED) ? TCTM_WB_WC : TCTM_WB_CA;
                end
                TCTM_WB_WC: if (brk_ack) state <= TCTM_WB_CA;
                TCTM_WB_CA: if (brk_ack) state <= finish_evt ? TCTM_IDLE : TCTM_WAIT;
            endcase
        end
    end

    // break bus outputs, registered from next state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            brk_req   <= 1'b0;
            brk_we    <= 1'b0;
            brk_addr  <= '0;
            brk_wdata <= '0;
        end else begin
            brk_req   <= 1'b0;
            brk_we    <= 1'b0;
            unique case (state)
                TCTM_IDLE: if (start_req) begin
                    brk_req  <= 1'b1;
                    brk_addr <= AW'((start_mode == TCTM_COUNT_PACED) ? `TCTM_WC_LOC : `TCTM_CA_LOC);
                end
                TCTM_FETCH_WC: begin
                    brk_req  <= 1'b1;
                    brk_addr <= AW'(brk_ack ? `TCTM_CA_LOC : `TCTM_WC_LOC);
                end
                TCTM_FETCH_CA: brk_req <= !brk_ack;
                TCTM_WAIT: if (tape_word_valid && !overflowed && !finish_evt) begin  // R6
                    brk_req   <= 1'b1;
                    brk_we    <= 1'b1;
                    brk_addr  <= AW'(current_address);                            // R4
                    brk_wdata <= tape_word;
                end
                TCTM_XFER: begin
                    brk_req <= 1'b1;
                    brk_we  <= 1'b1;
                    if (brk_ack) begin
                        brk_addr  <= AW'((mode == TCTM_COUNT_PACED) ? `TCTM_WC_LOC : `TCTM_CA_LOC);
                        brk_wdata <= (mode == TCTM_COUNT_PACED) ? next_wc
                                     : current_address + {{(DW-1){1'b0}}, 1'b1};
                    end
                end
                TCTM_WB_WC: begin
                    brk_req <= 1'b1;
                    brk_we  <= 1'b1;
                    if (brk_ack) begin
                        brk_addr  <= AW'(`TCTM_CA_LOC);
                        brk_wdata <= current_address;
                    end
                end
                TCTM_WB_CA: begin
                    brk_req <= !brk_ack;
                    brk_we  <= !brk_ack;
                end
            endcase
        end
    end

endmodule : tctm_core

// ==== verif/tb_tape_control_transfer_modes.sv ====
`timescale 1ns/1ps
`include "tctm_regs.svh"
`define MEM i_tctm_mem_model.mem
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_tape_control_transfer_modes;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq, tmw, tmi;
    logic        brk_req, brk_we, brk_ack, tape_word_valid, tape_block_end;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [14:0] brk_addr;
    logic [17:0] brk_wdata, brk_rdata, tape_word, base, w;
    logic [15:0] acks;
    int          miscompares, n_checks, exp_acks, k;
    tctm_core i_tctm_core (.*, .timing_mark_write_position(tmw), .timing_mark_indicator(tmi));
    tctm_mem_model i_tctm_mem_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] st(input logic d, input logic t);
        return {20'h0, d, 5'h0, t, 5'h0};
    endfunction : st
    function automatic logic [31:0] info(input logic f, input logic m, input logic b);
        return {29'h0, b, m, f};
    endfunction : info
    task automatic end_sim();
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 20) miscompares++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rdc
    task automatic wait_to(input int n);
        int t;
        t = 0;
        exp_acks += n;
        while (acks != 16'(exp_acks) && t < 100) begin
            @(posedge clk_sys);
            t++;
        end
        repeat (6) @(posedge clk_sys);
        `CHK(acks, 16'(exp_acks))
    endtask : wait_to
    task automatic send(input int n);
        w = 18'($urandom);
        tape_word       <= w;
        tape_word_valid <= 1'b1;
        @(posedge clk_sys);
        tape_word_valid <= 1'b0;
        wait_to(n);
    endtask : send
    task automatic start(input logic m);
        base = 18'h40 + 18'($urandom_range(63));
        `MEM[`TCTM_CA_LOC] = base;
        bus(1'b1, `TCTM_OFS_CTRL, {30'h0, 1'b1, m});
        wait_to(m ? 2 : 1);
    endtask : start
    task automatic blk();
        tape_block_end <= 1'b1;
        @(posedge clk_sys);
        tape_block_end <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : blk
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, tmw} = '0;
        {tape_word_valid, tape_word, tape_block_end} = '0;
        {miscompares, n_checks, exp_acks} = '0;
        void'($urandom(70));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(`TCTM_OFS_INFO, info(0, 0, 0));
        rdc(4'h1, 32'h0);
        bus(1'b1, `TCTM_OFS_MASK, 32'h820);
        // a count that would overflow at once must be ignored here
        `MEM[`TCTM_WC_LOC] = 18'h3ffff;
        start(1'b0);
        for (k = 0; k < 3; k++) begin
            send(2);
            `CHK(`MEM[base + k], w)
        end
        rdc(`TCTM_OFS_STATUS, st(0, 0));
        blk();
        rdc(`TCTM_OFS_STATUS, st(1, 0));
        `CHK(irq, 1'b1)
        `CHK(`MEM[`TCTM_CA_LOC], base + 18'd3)
        start(1'b0);
        blk();
        rdc(`TCTM_OFS_STATUS, st(1, 1));
        bus(1'b1, `TCTM_OFS_STATUS, st(1, 1));
        @(posedge clk_sys);
        `CHK(irq, 1'b0)
        `MEM[`TCTM_WC_LOC] = 18'h3fffd;
        start(1'b1);
        for (k = 0; k < 3; k++) begin
            if (k == 2) rdc(`TCTM_OFS_STATUS, st(0, 0));
            if (k == 2) rdc(`TCTM_OFS_INFO, info(1, 1, 1));
            send(3);
            `CHK(`MEM[base + k], w)
        end
        rdc(`TCTM_OFS_STATUS, st(1, 0));
        rdc(`TCTM_OFS_INFO, info(0, 1, 0));
        `CHK(`MEM[`TCTM_WC_LOC], 18'h0)
        send(0);
        bus(1'b1, `TCTM_OFS_MASK, 32'h0);
        @(posedge clk_sys);
        `CHK(irq, 1'b0)
        for (k = 0; k < 4; k++) begin
            tmw <= 1'($urandom_range(1));
            repeat (5) @(posedge clk_sys);
            `CHK(tmi, tmw)
        end
        end_sim();
    end
    initial begin
        #(20000 * 10);
        miscompares++;
        end_sim();
    end
endmodule : tb_tape_control_transfer_modes

// ==== verif/tctm_chk.sv ====
`timescale 1ns/1ps
`include "tctm_regs.svh"
module tctm_chk
    import tctm_pkg::*;
#(
    parameter int AW = 15,
    parameter int DW = 18
) (
    // clock, reset, bus
    input wire logic          clk_sys,
    input wire logic          rst,
    input wire logic [3:0]    avs_address,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic [31:0]   avs_writedata,
    input wire logic [31:0]   avs_readdata,
    input wire logic          avs_waitrequest,
    input wire logic          irq,
    // break channel
    input wire logic          brk_req,
    input wire logic          brk_we,
    input wire logic [AW-1:0] brk_addr,
    input wire logic [DW-1:0] brk_wdata,
    input wire logic [DW-1:0] brk_rdata,
    input wire logic          brk_ack,
    // tape and panel
    input wire logic          tape_word_valid,
    input wire logic [DW-1:0] tape_word,
    input wire logic          tape_block_end,
    input wire logic          timing_mark_write_position,
    input wire logic          timing_mark_indicator
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [DW-1:0] wc_q, ca_q;
    logic          ovf_q;
    wire           done = brk_req && brk_ack;
    // any bus write may start a new function, so the flag is dropped early
    always_ff @(posedge clk_sys) begin
        if (rst || avs_write) ovf_q <= 1'b0;
        else if (done && brk_we && brk_addr == `TCTM_WC_LOC && brk_wdata == '0) ovf_q <= 1'b1;
    end
    always_ff @(posedge clk_sys) begin
        if (done && brk_addr == `TCTM_WC_LOC) wc_q <= brk_we ? brk_wdata : brk_rdata;
        if (done && brk_addr == `TCTM_CA_LOC) ca_q <= brk_we ? brk_wdata : brk_rdata;
    end
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
    endsequence
    sequence ca_wb_s;
        brk_req && brk_we && brk_addr == `TCTM_CA_LOC;
    endsequence
    rst_idle_a: assert property ($fell(rst) |-> avs_waitrequest && !brk_req && !irq)
        else $error("outputs not idle after reset");
    wait_one_a: assert property (taken_s |=> !avs_waitrequest)
        else $error("bus answer late");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    brk_hold_a: assert property (brk_req && !brk_ack |=> brk_req && $stable(brk_addr) && $stable(brk_wdata))
        else $error("break request dropped");
    tmark_delay_a: assert property ((!rst)[*4] |-> timing_mark_indicator == $past(timing_mark_write_position, 3))
        else $error("timing mark indicator wrong");
    no_break_a: assert property (ovf_q && brk_req |-> ca_wb_s)
        else $error("break after overflow");
    data_addr_a: assert property (brk_req && brk_we && brk_addr != `TCTM_WC_LOC && brk_addr != `TCTM_CA_LOC
        |-> brk_addr == ca_q[AW-1:0])
        else $error("data address wrong");
    ca_step_a: assert property (ca_wb_s |-> brk_wdata == ca_q + 1'b1)
        else $error("address not advanced");
    wc_step_a: assert property (brk_req && brk_we && brk_addr == `TCTM_WC_LOC |-> brk_wdata == wc_q + 1'b1)
        else $error("count not advanced");
endmodule : tctm_chk
bind tctm_core tctm_chk #(.AW(AW), .DW(DW)) i_tctm_chk (.*);

// ==== verif/tctm_mem_model.sv ====
`timescale 1ns/1ps
module tctm_mem_model (
    // break channel
    input wire logic   clk_sys,
    input wire logic   brk_req,
    input wire logic   brk_we,
    input wire logic [14:0] brk_addr,
    input wire logic [17:0] brk_wdata,
    output logic [17:0] brk_rdata,
    output logic        brk_ack,
    output logic [15:0] acks
);
    logic [17:0] mem [0:255];
    int          dly = 0;
    initial begin
        brk_ack = 1'b0;
        brk_rdata = '0;
        acks = '0;
    end
    // data toggles between answers so stale reads never match
    always @(posedge clk_sys) begin
        brk_rdata <= ~brk_rdata;
        brk_ack   <= 1'b0;
        if (brk_req && !brk_ack) begin
            if (dly == 0) begin
                brk_ack <= 1'b1;
                acks    <= acks + 16'h1;
                if (brk_we) mem[brk_addr[7:0]] <= brk_wdata;
                else brk_rdata <= mem[brk_addr[7:0]];
                dly = $urandom_range(3);
            end else dly = dly - 1;
        end
    end
endmodule : tctm_mem_model
